// [common/pma_defines.svh]
// Offsets, field positions, reset values and timing counts
`ifndef PMA_DEFINES_SVH
`define PMA_DEFINES_SVH
// ****************************************
// Core-side register indices
// ****************************************
`define PMA_SFR_SELECT 3'h0
`define PMA_SFR_WR_LOW 3'h1
`define PMA_SFR_WR_HIGH 3'h2
`define PMA_SFR_RD_LOW 3'h3
`define PMA_SFR_RD_HIGH 3'h4
`define PMA_SFR_CMD 3'h5
`define PMA_SFR_STATUS 3'h6
// Command and status bit positions
`define PMA_CMD_READ_BIT 0
`define PMA_CMD_SCAN_BIT 1
`define PMA_ST_BUSY_BIT 0
`define PMA_ST_SCAN_BIT 1
`define PMA_ST_NOT_VALID_BIT 2
// ****************************************
// PHY register addresses
// ****************************************
`define PMA_PHY_CONTROL_ONE 5'h00
`define PMA_PHY_STATUS_ONE 5'h01
`define PMA_PHY_CONTROL_TWO 5'h10
`define PMA_PHY_STATUS_TWO 5'h11
`define PMA_PHY_IRQ_ENABLE 5'h12
`define PMA_PHY_IRQ_FLAGS 5'h13
`define PMA_PHY_LED_CONTROL 5'h14
`define PMA_DUPLEX_BIT 8
`define PMA_LINK_HELD_BIT 2
`define PMA_LINK_NOW_BIT 10
`define PMA_RST_CONTROL_ONE 16'h0000
`define PMA_RST_CONTROL_TWO 16'h0000
`define PMA_RST_IRQ_ENABLE 16'h0000
`define PMA_RST_LED_CONTROL 16'h3422
`define PMA_STATUS_ONE_BASE 16'h1800
// ****************************************
// Timing
// ****************************************
`define PMA_CLK_PERIOD_NS 20
`define PMA_OP_TIME_NS 10240
`define PMA_OP_CYCLES (`PMA_OP_TIME_NS / `PMA_CLK_PERIOD_NS)
`define PMA_BUSY_DELAY 2
`endif

// [common/pma_pkg.sv]
// Types shared by the management access engine
package pma_pkg;
	// Engine states, one-hot
	typedef enum logic [2:0] {
		PMA_ST_IDLE = 3'b001,
		PMA_ST_ARM = 3'b010,
		PMA_ST_RUN = 3'b100
	} pma_state_t;
	// Kind of transaction in flight
	typedef enum logic [1:0] {
		PMA_OP_READ = 2'h0,
		PMA_OP_WRITE = 2'h1,
		PMA_OP_SCAN = 2'h2
	} pma_op_t;
endpackage : pma_pkg

// [common/pma_phy_if.sv]
// Carrier between the engine and the PHY register space
`timescale 1ns/1ps
interface pma_phy_if;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic wr_stb;
	logic [15:0] rdata;
	modport engine (output addr, output wdata, output wr_stb,
		input rdata);
	modport phy (input addr, input wdata, input wr_stb,
		output rdata);
endinterface : pma_phy_if

// [rtl/pma_phy_regs.sv]
// PHY register space reached over the management path
`timescale 1ns/1ps
`include "pma_defines.svh"
module pma_phy_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Management side
	pma_phy_if.phy mif,
	// PHY state
	input wire logic link_up,
	output logic phy_duplex_select
);
	import pma_pkg::*;
	logic [15:0] con1_reg, con1_next;
	logic [15:0] con2_reg, con2_next;
	logic [15:0] ie_reg, ie_next;
	logic [15:0] led_reg, led_next;
	logic link_seen_reg, link_seen_next;
	logic rd_one;

	// ****************************************
	// Register update
	// ****************************************
	// All sixteen bits land at once, no masking
	always_comb begin
		con1_next = con1_reg;
		con2_next = con2_reg;
		ie_next = ie_reg;
		led_next = led_reg;
		if (mif.wr_stb) begin
			case (mif.addr) // [R9]
				`PMA_PHY_CONTROL_ONE: con1_next = mif.wdata;
				`PMA_PHY_CONTROL_TWO: con2_next = mif.wdata;
				`PMA_PHY_IRQ_ENABLE: ie_next = mif.wdata;
				`PMA_PHY_LED_CONTROL: led_next = mif.wdata;
				default: ;
			endcase
		end
		// Latching link: drops on loss, rearms after a status read
		rd_one = (mif.addr == `PMA_PHY_STATUS_ONE);
		link_seen_next = link_seen_reg & link_up;
		if (rd_one && !mif.wr_stb)
			link_seen_next = link_up;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			con1_reg <= `PMA_RST_CONTROL_ONE;
			con2_reg <= `PMA_RST_CONTROL_TWO;
			ie_reg <= `PMA_RST_IRQ_ENABLE;
			led_reg <= `PMA_RST_LED_CONTROL;
			link_seen_reg <= 1'b0;
		end else begin
			con1_reg <= con1_next;
			con2_reg <= con2_next;
			ie_reg <= ie_next;
			led_reg <= led_next;
			link_seen_reg <= link_seen_next;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Unimplemented addresses read zero here
	always_comb begin
		mif.rdata = 16'h0000;
		case (mif.addr) // [R1]
			`PMA_PHY_CONTROL_ONE: mif.rdata = con1_reg;
			`PMA_PHY_STATUS_ONE: begin
				mif.rdata = `PMA_STATUS_ONE_BASE;
				mif.rdata[`PMA_LINK_HELD_BIT] = link_seen_reg;
			end
			`PMA_PHY_CONTROL_TWO: mif.rdata = con2_reg;
			`PMA_PHY_STATUS_TWO: mif.rdata[`PMA_LINK_NOW_BIT] = link_up;
			`PMA_PHY_IRQ_ENABLE: mif.rdata = ie_reg;
			`PMA_PHY_LED_CONTROL: mif.rdata = led_reg;
			default: mif.rdata = 16'h0000;
		endcase
	end

	// Duplex mode drives the PHY; the MAC must be set to match
	assign phy_duplex_select = con1_reg[`PMA_DUPLEX_BIT]; // [R15]
endmodule : pma_phy_regs

// [rtl/pma_engine.sv]
// PHY register management access engine with core-side registers
// Function
// [R1] A 5-bit register address picks one of 32 PHY locations.
// [R2] Software loads the address first, then sets the read command.
// [R3] Read command starts a read; busy rises two cycles later.
// [R4] A read takes 10.24 us, then busy clears by itself.
// [R5] While busy, software starts no scan and no high-byte write.
// [R6] Software clears the read command, then reads both result bytes.
// [R7] Address, low byte, high byte; high byte starts it, busy after two.
// [R8] PHY register updates when the 10.24 us operation ends; busy clears.
// [R9] PHY writes always update all sixteen bits together.
// [R10] Scan command sets not-valid and scan at once, busy two cycles on.
// [R11] First scan read clears not-valid; reads then repeat every 10.24 us.
// [R12] Software may not assume both scanned bytes share one sample.
// [R13] Clearing scan finishes the current read, then drops scan and busy.
// [R14] During scan software keeps the address and starts nothing new.
// [R15] Duplex bit 8 of control one; MAC duplex must match it.
// [R16] Software waits for the PHY ready flag before any access.
// [R17] Software never writes unimplemented addresses; keeps reserved bits.
`timescale 1ns/1ps
`include "pma_defines.svh"
module pma_engine #(
	parameter int OP_CYCLES = `PMA_OP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core register port
	input wire logic [2:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// PHY side
	input wire logic link_up,
	output logic phy_duplex_select,
	// Status levels
	output logic busy
);
	import pma_pkg::*;
	localparam int CW = $clog2(OP_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(OP_CYCLES - 1);
	localparam logic [CW-1:0] ARM_LAST = CW'(`PMA_BUSY_DELAY - 1);

	pma_phy_if mif ();

	pma_state_t state_reg, state_next;
	pma_op_t op_reg, op_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [4:0] sel_reg, sel_next;
	logic [7:0] wl_reg, wl_next;
	logic [7:0] wh_reg, wh_next;
	logic [15:0] rd_reg, rd_next;
	logic [1:0] cmd_reg, cmd_next;
	logic scan_reg, scan_next;
	logic nval_reg, nval_next;
	logic [7:0] rdata_next;
	logic idle, wr_cmd, rd_start, sc_start, wh_start, op_end;

	// ****************************************
	// Command decode
	// ****************************************
	// New work is only taken while idle; the core must wait anyway
	assign idle = (state_reg == PMA_ST_IDLE);
	assign wr_cmd = sfr_wr && (sfr_addr == `PMA_SFR_CMD);
	assign rd_start = wr_cmd && idle && !cmd_reg[`PMA_CMD_READ_BIT]
		&& sfr_wdata[`PMA_CMD_READ_BIT]; // [R3]
	assign sc_start = wr_cmd && idle && !cmd_reg[`PMA_CMD_SCAN_BIT]
		&& sfr_wdata[`PMA_CMD_SCAN_BIT]; // [R10]
	assign wh_start = sfr_wr && idle
		&& (sfr_addr == `PMA_SFR_WR_HIGH); // [R7]
	assign op_end = (state_reg == PMA_ST_RUN) && (cnt_reg == LAST);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		cnt_next = cnt_reg;
		sel_next = sel_reg;
		wl_next = wl_reg;
		wh_next = wh_reg;
		rd_next = rd_reg;
		cmd_next = cmd_reg;
		scan_next = scan_reg;
		nval_next = nval_reg;
		// Register writes from the core
		if (sfr_wr) begin
			case (sfr_addr)
				`PMA_SFR_SELECT: sel_next = sfr_wdata[4:0]; // [R1]
				`PMA_SFR_WR_LOW: wl_next = sfr_wdata;
				`PMA_SFR_WR_HIGH: wh_next = sfr_wdata;
				`PMA_SFR_CMD: cmd_next = sfr_wdata[1:0];
				default: ;
			endcase
		end
		// Transaction sequencing
		case (state_reg)
			PMA_ST_IDLE: begin
				cnt_next = '0;
				if (sc_start) begin
					state_next = PMA_ST_ARM;
					op_next = PMA_OP_SCAN;
					scan_next = 1'b1; // [R10]
					nval_next = 1'b1;
				end else if (rd_start) begin
					state_next = PMA_ST_ARM;
					op_next = PMA_OP_READ;
				end else if (wh_start) begin
					state_next = PMA_ST_ARM;
					op_next = PMA_OP_WRITE;
				end
			end
			// Two-cycle hold-off before busy shows
			PMA_ST_ARM: begin
				if (cnt_reg == ARM_LAST) begin // [R3] [R7] [R10]
					state_next = PMA_ST_RUN;
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			PMA_ST_RUN: begin
				cnt_next = cnt_reg + 1'b1;
				if (op_end) begin // [R4] [R8]
					cnt_next = '0;
					if (op_reg != PMA_OP_WRITE) begin
						rd_next = mif.rdata;
						nval_next = 1'b0; // [R11]
					end
					// Scan keeps going while its command bit stays set
					if (op_reg == PMA_OP_SCAN
						&& cmd_next[`PMA_CMD_SCAN_BIT]) begin // [R11]
						state_next = PMA_ST_RUN;
					end else begin
						state_next = PMA_ST_IDLE; // [R13]
						scan_next = 1'b0;
					end
				end
			end
			default: state_next = PMA_ST_IDLE;
		endcase
	end

	// Core read data is registered, one cycle after the address
	always_comb begin
		case (sfr_addr)
			`PMA_SFR_SELECT: rdata_next = {3'h0, sel_reg};
			`PMA_SFR_WR_LOW: rdata_next = wl_reg;
			`PMA_SFR_WR_HIGH: rdata_next = wh_reg;
			`PMA_SFR_RD_LOW: rdata_next = rd_reg[7:0];
			`PMA_SFR_RD_HIGH: rdata_next = rd_reg[15:8];
			`PMA_SFR_CMD: rdata_next = {6'h00, cmd_reg};
			`PMA_SFR_STATUS: rdata_next = {5'h00, nval_reg,
				scan_reg, busy};
			default: rdata_next = 8'h00;
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= PMA_ST_IDLE;
			op_reg <= PMA_OP_READ;
			cnt_reg <= '0;
			sel_reg <= 5'h00;
			wl_reg <= 8'h00;
			wh_reg <= 8'h00;
			rd_reg <= 16'h0000;
			cmd_reg <= 2'h0;
			scan_reg <= 1'b0;
			nval_reg <= 1'b0;
			sfr_rdata <= 8'h00;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			cnt_reg <= cnt_next;
			sel_reg <= sel_next;
			wl_reg <= wl_next;
			wh_reg <= wh_next;
			rd_reg <= rd_next;
			cmd_reg <= cmd_next;
			scan_reg <= scan_next;
			nval_reg <= nval_next;
			sfr_rdata <= rdata_next;
		end
	end

	// Busy spans exactly the run phase
	assign busy = (state_reg == PMA_ST_RUN);
	// ****************************************
	// PHY access
	// ****************************************
	assign mif.addr = sel_reg; // [R1]
	assign mif.wdata = {wh_reg, wl_reg}; // [R9]
	assign mif.wr_stb = op_end && (op_reg == PMA_OP_WRITE); // [R8]

	pma_phy_regs u_phy (
		.clk(clk),
		.rst(rst),
		.mif(mif),
		.link_up(link_up),
		.phy_duplex_select(phy_duplex_select)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] blen_reg, blen_next;
	// Length of the current busy stretch, for the timing checks
	always_comb begin
		blen_next = busy ? blen_reg + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk) begin
		if (rst)
			blen_reg <= 16'h0000;
		else
			blen_reg <= blen_next;
	end
	sequence s_hold_two;
		!busy ##1 !busy ##1 busy;
	endsequence
	a_read_busy_delay: assert property (rd_start && !sc_start |=> // [R3]
		s_hold_two) else $error("read busy delay wrong");
	a_write_busy_delay: assert property (wh_start && !wr_cmd |=> // [R7]
		s_hold_two) else $error("write busy delay wrong");
	a_scan_flags: assert property (sc_start |=> // [R10]
		scan_reg && nval_reg ##0 s_hold_two)
		else $error("scan flags wrong");
	// At the fall, the count already holds every busy cycle of the stretch
	a_op_length: assert property ($fell(busy) |-> // [R4]
		(blen_reg % OP_CYCLES) == 0)
		else $error("operation length wrong");
	a_write_commit: assert property (mif.wr_stb |=> // [R8]
		!busy && $past(blen_reg) == 16'(OP_CYCLES - 1))
		else $error("write commit timing wrong");
	// Control one, control two and LED control must read back the whole word that went out
	a_write_whole: assert property (mif.wr_stb && // [R9]
		(mif.addr == `PMA_PHY_CONTROL_ONE
		|| mif.addr == `PMA_PHY_CONTROL_TWO
		|| mif.addr == `PMA_PHY_LED_CONTROL) |=>
		!$stable(mif.addr) || mif.rdata == $past(mif.wdata))
		else $error("write data not whole word");
	a_scan_valid: assert property ($fell(nval_reg) |-> // [R11]
		$past(op_end) && rd_reg == $past(mif.rdata))
		else $error("not-valid cleared off cycle");
	a_scan_stop: assert property ($fell(scan_reg) |-> // [R13]
		$fell(busy) && !cmd_reg[`PMA_CMD_SCAN_BIT])
		else $error("scan stop wrong");
endmodule : pma_engine

// [testbench/pma_link_model.sv]
// Model of the PHY link state seen by the engine
`timescale 1ns/1ps
module pma_link_model (
	// Clock
	input wire logic clk,
	// Requested link state
	input wire logic link_cmd,
	// Link level towards the engine
	output logic link_up
);
	logic link_q = 1'b1;
	// A real link settles a cycle after the cable changes, not instantly
	always @(posedge clk) begin
		link_q <= link_cmd;
	end
	assign link_up = link_q;
endmodule : pma_link_model

// [testbench/test_phy_register_mgmt_access.sv]
// Self-checking testbench of the management access engine
`timescale 1ns/1ps
`include "pma_defines.svh"
module test_phy_register_mgmt_access;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int OPC = 8;
	logic clk, rst, sfr_wr, link_cmd, link_up, duplex, busy;
	logic [2:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, b;
	logic [15:0] w;
	int num_errors, samples_checked;
	pma_engine #(.OP_CYCLES(OPC)) u_pma_engine (.clk(clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .link_up(link_up),
		.phy_duplex_select(duplex), .busy(busy));
	pma_link_model u_pma_link_model (.clk(clk), .link_cmd(link_cmd),
		.link_up(link_up));
	// ****************************************
	// Bus and compare tasks
	// ****************************************
	// All tasks start and end 1 ns after a rising edge
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk
	// The strobe stays up between back-to-back writes; the next rd,
	// wait_cycles or busy_rise call is the one that drops it
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		sfr_wr = 1'b0;
		sfr_addr = a;
		@(posedge clk);
		#1;
		d = sfr_rdata;
	endtask : rd
	task automatic wait_cycles(input int n);
		sfr_wr = 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cycles
	// Edges from command to busy; bounded so a dead engine cannot hang
	task automatic busy_rise(input int exp);
		int n;
		n = 0;
		sfr_wr = 1'b0;
		while (busy !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(exp));
	endtask : busy_rise
	task automatic busy_run(input int exp);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 3 * OPC) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(exp));
	endtask : busy_run
	task automatic phy_wr(input logic [4:0] a, input logic [15:0] v);
		wr(`PMA_SFR_SELECT, {3'h0, a});
		wr(`PMA_SFR_WR_LOW, v[7:0]);
		wr(`PMA_SFR_WR_HIGH, v[15:8]);
		busy_rise(2);
		busy_run(OPC);
	endtask : phy_wr
	task automatic phy_rd(input logic [4:0] a, output logic [15:0] v);
		wr(`PMA_SFR_SELECT, {3'h0, a});
		wr(`PMA_SFR_CMD, 8'h01);
		busy_rise(2);
		busy_run(OPC);
		wr(`PMA_SFR_CMD, 8'h00);
		rd(`PMA_SFR_RD_LOW, v[7:0]);
		rd(`PMA_SFR_RD_HIGH, v[15:8]);
	endtask : phy_rd
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk({15'h0, busy}, 16'h0000);
		chk({15'h0, duplex}, 16'h0000);
		rd(`PMA_SFR_STATUS, b);
		chk({8'h0, b}, 16'h0000);
		rd(3'h7, b);
		chk({8'h0, b}, 16'h0000);
		phy_rd(`PMA_PHY_LED_CONTROL, w);
		chk(w, `PMA_RST_LED_CONTROL);
		phy_rd(`PMA_PHY_CONTROL_TWO, w);
		chk(w, `PMA_RST_CONTROL_TWO);
		$display("reset test done");
	endtask : t_reset
	task automatic t_write();
		phy_wr(`PMA_PHY_CONTROL_ONE, 16'h0100);
		chk({15'h0, duplex}, 16'h0001);
		phy_rd(`PMA_PHY_CONTROL_ONE, w);
		chk(w, 16'h0100);
		phy_wr(`PMA_PHY_CONTROL_TWO, 16'h4110);
		phy_rd(`PMA_PHY_CONTROL_TWO, w);
		chk(w, 16'h4110);
		// The staging registers read back what the last write left there
		rd(`PMA_SFR_WR_LOW, b);
		chk({8'h0, b}, 16'h0010);
		rd(`PMA_SFR_WR_HIGH, b);
		chk({8'h0, b}, 16'h0041);
		rd(`PMA_SFR_SELECT, b);
		chk({8'h0, b}, 16'h0010);
		phy_wr(`PMA_PHY_CONTROL_ONE, 16'h0000);
		chk({15'h0, duplex}, 16'h0000);
		$display("write test done");
	endtask : t_write
	// A high-byte write while the first is armed starts nothing new, but
	// the byte is still stored and goes out with the write in flight
	task automatic t_refuse();
		wr(`PMA_SFR_SELECT, {3'h0, `PMA_PHY_LED_CONTROL});
		wr(`PMA_SFR_WR_LOW, 8'h46);
		wr(`PMA_SFR_WR_HIGH, 8'h35);
		wr(`PMA_SFR_WR_HIGH, 8'h3F);
		busy_rise(1);
		busy_run(OPC);
		phy_rd(`PMA_PHY_LED_CONTROL, w);
		chk(w, 16'h3F46);
		$display("refuse test done");
	endtask : t_refuse
	task automatic t_scan();
		wr(`PMA_SFR_SELECT, {3'h0, `PMA_PHY_STATUS_TWO});
		wr(`PMA_SFR_CMD, 8'h02);
		rd(`PMA_SFR_STATUS, b);
		chk({8'h0, b}, 16'h0006);
		busy_rise(1);
		// The address is left alone for as long as the scan runs
		wait_cycles(OPC - 3);
		rd(`PMA_SFR_STATUS, b);
		chk({8'h0, b}, 16'h0007);
		wait_cycles(3);
		rd(`PMA_SFR_STATUS, b);
		chk({8'h0, b}, 16'h0003);
		// Only the high byte holds the link bit, so no pairing is assumed
		rd(`PMA_SFR_RD_HIGH, b);
		chk({8'h0, b}, 16'h0004);
		link_cmd = 1'b0;
		wait_cycles(2 * OPC + 2);
		rd(`PMA_SFR_RD_HIGH, b);
		chk({8'h0, b}, 16'h0000);
		wr(`PMA_SFR_CMD, 8'h00);
		chk({15'h0, busy}, 16'h0001);
		wait_cycles(OPC + 2);
		rd(`PMA_SFR_STATUS, b);
		chk({8'h0, b}, 16'h0000);
		link_cmd = 1'b1;
		$display("scan test done");
	endtask : t_scan
	// ****************************************
	// Clock, sequence, watchdog and verdict
	// ****************************************
	task automatic finish_test();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_addr = 3'h0;
		sfr_wdata = 8'h00;
		link_cmd = 1'b1;
		num_errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		// The modelled PHY is ready as soon as reset ends, so no poll
		t_reset();
		t_write();
		t_refuse();
		t_scan();
		finish_test();
	end
	// The whole run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		finish_test();
	end
endmodule : test_phy_register_mgmt_access
